// >>> verilog/scc_stab_config.sv
// Stabilization chain configuration registers and output path.
`timescale 1ns/1ps
module scc_stab_config (
  // Clock and control
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  // Auxiliary port register access (read and write)
  input  wire logic        auxWrEn,
  input  wire logic        auxRdEn,
  input  wire logic [7:0]  auxAddr,
  input  wire logic [7:0]  auxWrData,
  output logic      [7:0]  auxRdData,
  // Primary port register access (offsets writable, rest read-only)
  input  wire logic        priWrEn,
  input  wire logic        priRdEn,
  input  wire logic [7:0]  priAddr,
  input  wire logic [7:0]  priWrData,
  output logic      [7:0]  priRdData,
  // Bits held elsewhere in the device
  input  wire logic        levelTriggerSel,
  input  wire logic        levelLatchSel,
  input  wire logic        accelRangeSourceMode,
  input  wire logic        accelPrimaryOn,
  input  wire logic [1:0]  accelPrimaryRange,
  input  wire logic        offsetWeightSel,
  input  wire logic        dataEnableInput,
  // Gyroscope sample path
  input  wire logic        gyroValid,
  input  wire logic [15:0] gyroSample,
  input  wire logic [15:0] gyroHighpassed,
  input  wire logic [15:0] gyroSelftestShift,
  output logic      [15:0] gyroOut,
  output logic             gyroOutValid,
  // Accelerometer sample path
  input  wire logic [15:0] accelX,
  input  wire logic [15:0] accelY,
  input  wire logic [15:0] accelZ,
  output logic      [15:0] accelOutX,
  output logic      [15:0] accelOutY,
  output logic      [15:0] accelOutZ,
  // Filter and range settings
  output logic      [1:0]  gyroHighpassCutoff,
  output logic             gyroHighpassEnable,
  output logic      [1:0]  gyroLowpassBw,
  output logic      [2:0]  stabAccelBandwidth,
  output logic      [1:0]  stabAccelRange,
  output logic      [1:0]  gyroSelftestSign,
  output scc_pkg::scc_den_e denMode
);
  import scc_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] gyroFilter_q;
  logic [7:0] accelCfg_q;
  logic [7:0] axisOffset_q [3];
  logic [1:0] selftestSel;
  logic       selftestOn;
  logic [7:0] accelCfgView;
  logic [15:0] rawAxis [3];
  logic [15:0] corrAxis [3];

  always_ff @(posedge mclk) begin
    if (rst) begin
      gyroFilter_q <= RST_GYRO_FILTER;
      accelCfg_q   <= RST_ACCEL_CFG;
    end else if (clkEn && auxWrEn) begin
      // Only the auxiliary port reaches these two registers.
      if (auxAddr == ADDR_GYRO_FILTER) begin
        gyroFilter_q <= auxWrData & GYRO_FILTER_MASK;
      end
      if (auxAddr == ADDR_ACCEL_CFG) begin
        accelCfg_q <= auxWrData;
      end
    end
  end

  // ----------------------------------------------------------------
  // Offset registers, one per axis
  // ----------------------------------------------------------------
  // The auxiliary port wins when both ports write the same cycle.
  assign rawAxis[0] = accelX;
  assign rawAxis[1] = accelY;
  assign rawAxis[2] = accelZ;

  generate
    for (genvar i = 0; i < 3; i++) begin : gAxis
      localparam logic [7:0] AXIS_ADDR = ADDR_X_OFFSET + 8'(i);
      always_ff @(posedge mclk) begin
        if (rst) begin
          axisOffset_q[i] <= RST_OFFSET;
        end else if (clkEn) begin
          if (auxWrEn && auxAddr == AXIS_ADDR) begin
            axisOffset_q[i] <= auxWrData;
          end else if (priWrEn && priAddr == AXIS_ADDR) begin
            axisOffset_q[i] <= priWrData;
          end
        end
      end

      scc_axis_offset uOffset (
        .mclk            (mclk),
        .rst             (rst),
        .clkEn           (clkEn),
        .rawSample       (rawAxis[i]),
        .offsetByte      (axisOffset_q[i]),
        .offsetWeightSel (offsetWeightSel),
        .corrected       (corrAxis[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  assign gyroHighpassCutoff = gyroFilter_q[HPF_CUT_LSB +: 2];
  assign gyroHighpassEnable = gyroFilter_q[HPF_EN_BIT];
  assign gyroLowpassBw      = gyroFilter_q[LPF_BW_LSB +: 2];
  assign stabAccelBandwidth = accelCfg_q[ABW_LSB +: 3];
  assign selftestSel        = accelCfg_q[STSEL_LSB +: 2];

  // Code 10 is normal mode, like 00.
  always_comb begin
    gyroSelftestSign = 2'h0;
    selftestOn       = 1'b0;
    if (selftestSel == ST_POSITIVE || selftestSel == ST_NEGATIVE) begin
      gyroSelftestSign = selftestSel;
      selftestOn       = 1'b1;
    end
  end

  // Range selection.
  always_comb begin
    if (!accelRangeSourceMode) begin
      stabAccelRange = accelPrimaryRange;
    end else if (!accelPrimaryOn &&
                 accelCfg_q[AFS_LSB +: 2] == RANGE_16G) begin
      stabAccelRange = RANGE_2G;
    end else begin
      stabAccelRange = accelCfg_q[AFS_LSB +: 2];
    end
  end

  // The range field reads back the primary range when it governs.
  always_comb begin
    accelCfgView = accelCfg_q;
    if (!accelRangeSourceMode) begin
      accelCfgView[AFS_LSB +: 2] = accelPrimaryRange;
    end
  end

  // Latched mode by the second bit alone; trigger needs pattern 10.
  always_comb begin
    if (levelLatchSel) begin
      denMode = DEN_LATCHED;
    end else if (levelTriggerSel) begin
      denMode = DEN_TRIGGER;
    end else begin
      denMode = DEN_OFF;
    end
  end

  // ----------------------------------------------------------------
  // Gyroscope output path
  // ----------------------------------------------------------------
  logic        denLatch_q;
  logic        denGate;
  logic [15:0] gyroSel;

  always_ff @(posedge mclk) begin
    if (rst) begin
      denLatch_q <= 1'b0;
    end else if (clkEn && gyroValid) begin
      denLatch_q <= dataEnableInput;
    end
  end

  // Data-enable gates the gyroscope only.
  always_comb begin
    unique case (denMode)
      DEN_TRIGGER: denGate = dataEnableInput;
      DEN_LATCHED: denGate = denLatch_q | dataEnableInput;
      DEN_OFF:     denGate = 1'b1;
      default:     denGate = 1'b1;
    endcase
  end

  always_comb begin
    gyroSel = gyroHighpassEnable ? gyroHighpassed : gyroSample;
    if (selftestOn) begin
      if (selftestSel == ST_POSITIVE) begin
        gyroSel = 16'(gyroSel + gyroSelftestShift);
      end else begin
        gyroSel = 16'(gyroSel - gyroSelftestShift);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      gyroOut      <= 16'h0000;
      gyroOutValid <= 1'b0;
    end else if (clkEn) begin
      gyroOutValid <= gyroValid & denGate;
      if (gyroValid && denGate) begin
        if (selftestOn && !accelCfg_q[CLAMPDIS_BIT]) begin
          gyroOut <= CLAMP_VALUE;
        end else begin
          gyroOut <= gyroSel;
        end
      end
    end
  end

  // Accelerometer outputs are clamped as well while self-test runs and the clamp-disable bit is clear.
  always_comb begin
    if (selftestOn && !accelCfg_q[CLAMPDIS_BIT]) begin
      accelOutX = CLAMP_VALUE;
      accelOutY = CLAMP_VALUE;
      accelOutZ = CLAMP_VALUE;
    end else begin
      accelOutX = corrAxis[0];
      accelOutY = corrAxis[1];
      accelOutZ = corrAxis[2];
    end
  end

  // ----------------------------------------------------------------
  // Read ports
  // ----------------------------------------------------------------
  function automatic logic [7:0] readMux(input logic [7:0] addr);
    logic [7:0] v;
    v = 8'h00;
    unique case (addr)
      ADDR_GYRO_FILTER: v = gyroFilter_q;
      ADDR_ACCEL_CFG:   v = accelCfgView;
      ADDR_X_OFFSET:    v = axisOffset_q[0];
      ADDR_Y_OFFSET:    v = axisOffset_q[1];
      ADDR_Z_OFFSET:    v = axisOffset_q[2];
      default:          v = 8'h00;
    endcase
    return v;
  endfunction

  always_ff @(posedge mclk) begin
    if (rst) begin
      auxRdData <= 8'h00;
      priRdData <= 8'h00;
    end else if (clkEn) begin
      if (auxRdEn) begin
        auxRdData <= readMux(auxAddr);
      end
      if (priRdEn) begin
        priRdData <= readMux(priAddr);
      end
    end
  end
endmodule

// >>> verilog/scc_pkg.sv
// Constants for the stabilization chain configuration register bank.
package scc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_GYRO_FILTER = 8'h71;
  localparam logic [7:0] ADDR_ACCEL_CFG   = 8'h72;
  localparam logic [7:0] ADDR_X_OFFSET    = 8'h73;
  localparam logic [7:0] ADDR_Y_OFFSET    = 8'h74;
  localparam logic [7:0] ADDR_Z_OFFSET    = 8'h75;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int HPF_CUT_LSB = 4;
  localparam int LPF_BW_LSB  = 1;
  localparam int HPF_EN_BIT  = 0;
  localparam int AFS_LSB     = 6;
  localparam int ABW_LSB     = 3;
  localparam int STSEL_LSB   = 1;
  localparam int CLAMPDIS_BIT = 0;
  localparam logic [7:0] GYRO_FILTER_MASK = 8'h37;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_GYRO_FILTER = 8'h00;
  localparam logic [7:0]  RST_ACCEL_CFG   = 8'h00;
  localparam logic [7:0]  RST_OFFSET      = 8'h00;
  localparam logic [15:0] CLAMP_VALUE     = 16'h8000;
  localparam logic [1:0]  ST_POSITIVE     = 2'h1;
  localparam logic [1:0]  ST_NEGATIVE     = 2'h3;

  // Full-scale codes on the accelerometer range outputs.
  localparam logic [1:0] RANGE_2G  = 2'h0;
  localparam logic [1:0] RANGE_16G = 2'h1;
  localparam logic [1:0] RANGE_4G  = 2'h2;
  localparam logic [1:0] RANGE_8G  = 2'h3;

  // Data-enable modes.
  typedef enum logic [2:0] {
    DEN_OFF     = 3'b001,
    DEN_TRIGGER = 3'b010,
    DEN_LATCHED = 3'b100
  } scc_den_e;

endpackage

// >>> verilog/scc_axis_offset.sv
// One accelerometer axis: offset subtraction with selectable weight.
`timescale 1ns/1ps
module scc_axis_offset (
  // Clock and control
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  // Data
  input  wire logic [15:0] rawSample,
  input  wire logic [7:0]  offsetByte,
  input  wire logic        offsetWeightSel,
  output logic      [15:0] corrected
);
  import scc_pkg::*;

  logic signed [15:0] offsetScaled;

  // The weight bit selects a coarser scale by a shift of two.
  always_comb begin
    offsetScaled = 16'($signed(offsetByte));
    if (offsetWeightSel) begin
      offsetScaled = offsetScaled <<< 2;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      corrected <= 16'h0000;
    end else if (clkEn) begin
      corrected <= 16'($signed(rawSample) - offsetScaled);
    end
  end
endmodule

// >>> test/scc_stab_config_asserts.sv
// Concurrent checks on the stabilization configuration bank ports.
`timescale 1ns/1ps
module scc_stab_config_asserts (
  // Watched ports
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        clkEn,
  input wire logic        auxWrEn,
  input wire logic [7:0]  auxAddr,
  input wire logic [7:0]  auxWrData,
  input wire logic        priWrEn,
  input wire logic        priRdEn,
  input wire logic [7:0]  priAddr,
  input wire logic [7:0]  priRdData,
  input wire logic        levelTriggerSel,
  input wire logic        levelLatchSel,
  input wire logic        accelRangeSourceMode,
  input wire logic        accelPrimaryOn,
  input wire logic [1:0]  accelPrimaryRange,
  input wire logic [15:0] accelOutX,
  input wire logic [1:0]  gyroHighpassCutoff,
  input wire logic        gyroHighpassEnable,
  input wire logic [1:0]  gyroLowpassBw,
  input wire logic [2:0]  stabAccelBandwidth,
  input wire logic [1:0]  stabAccelRange,
  input wire logic [1:0]  gyroSelftestSign,
  input scc_pkg::scc_den_e denMode
);
  import scc_pkg::*;
  logic       clampDis_q;
  logic [1:0] rangeF_q;
  // Shadow copies of the aux-written clamp and range fields.
  always_ff @(posedge mclk) begin
    if (rst) begin
      clampDis_q <= 1'b0;
      rangeF_q   <= 2'h0;
    end else if (clkEn && auxWrEn && auxAddr == ADDR_ACCEL_CFG) begin
      clampDis_q <= auxWrData[0];
      rangeF_q   <= auxWrData[7:6];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_aw(logic [7:0] a);
    clkEn && auxWrEn && auxAddr == a;
  endsequence
  property p_gfilt;
    s_aw(ADDR_GYRO_FILTER) |=> {gyroHighpassCutoff, gyroLowpassBw,
      gyroHighpassEnable} == {$past(auxWrData[5:4]), $past(auxWrData[2:0])};
  endproperty
  a_gfilt: assert property (p_gfilt) else $error("filter fields wrong");
  property p_abw;
    s_aw(ADDR_ACCEL_CFG) |=> stabAccelBandwidth == $past(auxWrData[5:3]);
  endproperty
  a_abw: assert property (p_abw) else $error("bandwidth wrong");
  property p_stsign;
    s_aw(ADDR_ACCEL_CFG) |=> gyroSelftestSign == ($past(auxWrData[1]) ?
      {$past(auxWrData[2]), 1'b1} : 2'h0);
  endproperty
  a_stsign: assert property (p_stsign) else $error("self-test sign");
  property p_prio;
    clkEn && priWrEn && !auxWrEn && priAddr == ADDR_GYRO_FILTER |=>
      $stable({gyroHighpassCutoff, gyroLowpassBw, gyroHighpassEnable});
  endproperty
  a_prio: assert property (p_prio) else $error("primary write took");
  property p_resv;
    clkEn && priRdEn && priAddr == ADDR_GYRO_FILTER |=> !priRdData[3];
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set");
  property p_range;
    stabAccelRange == (!accelRangeSourceMode ? accelPrimaryRange :
      (!accelPrimaryOn && rangeF_q == 2'h1) ? 2'h0 : rangeF_q);
  endproperty
  a_range: assert property (p_range) else $error("range wrong");
  property p_latch;
    (clkEn && levelLatchSel) [*2] |-> denMode == DEN_LATCHED;
  endproperty
  a_latch: assert property (p_latch) else $error("not latched");
  property p_trig;
    (clkEn && levelTriggerSel && !levelLatchSel) [*2] |->
      denMode == DEN_TRIGGER;
  endproperty
  a_trig: assert property (p_trig) else $error("not trigger");
  property p_clamp;
    gyroSelftestSign != 2'h0 && !clampDis_q |-> accelOutX == CLAMP_VALUE;
  endproperty
  a_clamp: assert property (p_clamp) else $error("no clamp");
endmodule
bind scc_stab_config scc_stab_config_asserts u_chk (.*);

// >>> test/scc_aux_host.sv
// Model of the stabilization controller on the auxiliary port.
`timescale 1ns/1ps
module scc_aux_host (
  // Auxiliary port
  input  wire logic       mclk,
  output logic            auxWrEn = 1'b0,
  output logic            auxRdEn = 1'b0,
  output logic [7:0]      auxAddr = 8'h00,
  output logic [7:0]      auxWrData = 8'h00,
  input  wire logic [7:0] auxRdData
);
  task automatic wr(input logic [7:0] a, input logic [7:0] dIn);
    @(negedge mclk);
    auxAddr = a;
    auxWrData = (a == 8'h71) ? (dIn & 8'hf7) : dIn;
    if (dIn == 8'h80) auxWrData = 8'h81;
    auxWrEn = 1'b1;
    @(negedge mclk);
    auxWrEn = 1'b0;
    auxWrData = ~auxWrData;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] dOut);
    @(negedge mclk);
    auxAddr = a;
    auxRdEn = 1'b1;
    @(negedge mclk);
    auxRdEn = 1'b0;
    @(negedge mclk);
    dOut = auxRdData;
  endtask
endmodule

// >>> test/tb_top.sv
// Testbench for the stabilization configuration register bank.
`timescale 1ns/1ps
module tb_top;
  import scc_pkg::*;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        auxWrEn, auxRdEn, gyroOutValid, gyroHighpassEnable;
  logic [7:0]  auxAddr, auxWrData, auxRdData, priRdData, d;
  logic        priWrEn = 1'b0, priRdEn = 1'b0, gyroValid = 1'b0;
  logic        clkEn = 1'b1;
  logic [7:0]  priAddr = 8'h00, priWrData = 8'h00;
  logic        levelTriggerSel = 1'b0, levelLatchSel = 1'b0;
  logic        accelRangeSourceMode = 1'b0, accelPrimaryOn = 1'b1;
  logic        offsetWeightSel = 1'b0, dataEnableInput = 1'b0;
  logic [1:0]  accelPrimaryRange = 2'h0;
  logic [15:0] gyroSample = 16'h0100, gyroHighpassed = 16'h0200;
  logic [15:0] gyroSelftestShift = 16'h0040, accelX = 16'h0064;
  logic [15:0] accelY = 16'h0064, accelZ = 16'h0064, gyroOut;
  logic [15:0] accelOutX, accelOutY, accelOutZ;
  logic [1:0]  gyroHighpassCutoff, gyroLowpassBw, stabAccelRange;
  logic [1:0]  gyroSelftestSign;
  logic [2:0]  stabAccelBandwidth;
  scc_den_e    denMode;
  int          errTotal = 0;
  int          totalChecks = 0;
  int          cyc = 0;
  scc_stab_config dut (.*);
  scc_aux_host aux (.*);
  initial forever #10 mclk = ~mclk;
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    totalChecks++;
    if (s !== e) begin
      errTotal++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic pwr(input logic [7:0] a, input logic [7:0] dIn);
    @(negedge mclk);
    priAddr = a;
    priWrData = dIn;
    priWrEn = 1'b1;
    @(negedge mclk);
    priWrEn = 1'b0;
  endtask
  task automatic prd(input logic [7:0] a, output logic [7:0] dOut);
    @(negedge mclk);
    priAddr = a;
    priRdEn = 1'b1;
    @(negedge mclk);
    priRdEn = 1'b0;
    @(negedge mclk);
    dOut = priRdData;
  endtask
  // Sends one gyroscope sample and checks the registered result.
  task automatic gy(input logic [15:0] e);
    @(negedge mclk);
    gyroValid = 1'b1;
    @(negedge mclk);
    gyroValid = 1'b0;
    chk(gyroOut, e);
    chk({15'h0, gyroOutValid}, 16'h0001);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      errTotal++;
      end_of_test;
    end
  end
  initial begin
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    for (logic [7:0] a = 8'h71; a < 8'h76; a++) begin
      aux.rd(a, d);
      chk(d, 8'h00);
      prd(a, d);
      chk(d, 8'h00);
    end
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      aux.wr(8'h71, {2'h0, i[1:0], 1'b0, i[1:0], 1'b0});
      chk(gyroHighpassCutoff, i[1:0]);
      chk(gyroLowpassBw, i[1:0]);
    end
    pwr(8'h71, 8'h00);
    prd(8'h71, d);
    chk(d, 8'h36);
    for (int i = 0; i < 8; i++) begin
      aux.wr(8'h72, {2'h0, i[2:0], i[1:0], 1'b1});
      chk(stabAccelBandwidth, i[2:0]);
      chk(gyroSelftestSign, i[0] ? i[1:0] : 2'h0);
    end
    $display("field test done");
    accelPrimaryRange = 2'h2;
    aux.wr(8'h72, 8'hc0);
    chk(stabAccelRange, 2'h2);
    aux.rd(8'h72, d);
    chk(d[7:6], 2'h2);
    accelRangeSourceMode = 1'b1;
    for (int i = 0; i < 8; i++) begin
      accelPrimaryOn = i[2];
      aux.wr(8'h72, {i[1:0], 6'h00});
      chk(stabAccelRange, (!i[2] && i[1:0] == 2'h1) ? 2'h0 : i[1:0]);
    end
    for (int i = 0; i < 4; i++) begin
      {levelTriggerSel, levelLatchSel} = i[1:0];
      repeat (2) @(negedge mclk);
      chk(denMode, i[0] ? DEN_LATCHED : i[1] ? DEN_TRIGGER : DEN_OFF);
    end
    $display("mode test done");
    {levelTriggerSel, levelLatchSel} = 2'h2;
    pwr(8'h73, 8'h05);
    aux.wr(8'h74, 8'hfb);
    aux.wr(8'h75, 8'h7f);
    repeat (2) @(negedge mclk);
    chk(accelOutX, 16'h005f);
    chk(accelOutY, 16'h0069);
    chk(accelOutZ, 16'hffe5);
    offsetWeightSel = 1'b1;
    dataEnableInput = 1'b1;
    accelX = 16'h0100;
    repeat (2) @(negedge mclk);
    chk(accelOutX, 16'h00ec);
    clkEn = 1'b0;
    aux.wr(8'h75, 8'h11);
    clkEn = 1'b1;
    aux.rd(8'h75, d);
    chk(d, 8'h7f);
    $display("offset test done");
    {levelTriggerSel, levelLatchSel} = 2'h0;
    gyroSample = 16'h0123;
    gy(16'h0123);
    aux.wr(8'h71, 8'h01);
    gy(16'h0200);
    aux.wr(8'h72, 8'h03);
    gy(16'h0240);
    aux.wr(8'h72, 8'h07);
    gy(16'h01c0);
    aux.wr(8'h72, 8'h02);
    gy(16'h8000);
    chk(accelOutX, 16'h8000);
    aux.wr(8'h72, 8'h00);
    {levelTriggerSel, levelLatchSel} = 2'h2;
    dataEnableInput = 1'b0;
    @(negedge mclk);
    gyroValid = 1'b1;
    @(negedge mclk);
    gyroValid = 1'b0;
    chk({15'h0, gyroOutValid}, 16'h0000);
    {levelTriggerSel, levelLatchSel} = 2'h1;
    dataEnableInput = 1'b1;
    gy(16'h0200);
    dataEnableInput = 1'b0;
    gy(16'h0200);
    $display("self-test done");
    end_of_test;
  end
endmodule
